// [src/dig_exec.sv]
// Execution of arithmetic, logical, bit and loop instruction groups.
// Assumes decoded operations arrive one per cycle with valid; operands come
// from the data ALU registers and the bit operand from the memory path.
// Behaviour
// RQ1: Arithmetic completes in one cycle and may update condition flags.
// RQ2: Arithmetic takes register operands only and never uses data buses.
// RQ3: Parallel moves allowed except divide, normalize, increment, decrement.
// RQ4: Logical ops one cycle in ALU; immediate control forms excepted.
// RQ5: Logical ops touch only accumulator bits 47-24.
// RQ6: Parallel move may write other accumulator portions same cycle.
// RQ7: Immediate mask set and clear forbid parallel moves.
// RQ8: Bit ops test one bit then leave, set, clear or invert it.
// RQ9: Carry flag takes tested bit value before modification.
// RQ10: Four bit ops: test-clear, test-set, test-toggle, test-only.
// RQ11: Loop iterations run with zero extra cycles.
// RQ12: Loop count comes from immediate or a register.
// RQ13: Loop start bumps stack pointer, pushes loop address and counter.
// RQ14: Loop counter then loaded with the new count.
// RQ15: First loop body address saved at loop start.
// RQ16: Loop termination pulls loop address and counter from stack.
// RQ17: Address modifier honoured by updating indirect modes only.
// RQ18: Second push of body start and status; end address minus one.
// RQ19: Loop start sets loop-active flag in status word.
// RQ20: At loop end test counter; decrement and restart, else terminate.
`timescale 1ns/10ps
module dig_exec
    import dig_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic op_valid_i,
    input dig_op_t op_i,
    input wire logic par_move_i,
    input wire logic [DIG_ACC_W-1:0] acc_i,
    input wire logic [DIG_WORD_W-1:0] src_i,
    input wire logic [DIG_WORD_W-1:0] bit_word_i,
    input wire logic [4:0] bit_sel_i,
    input wire logic [7:0] imm_mask_i,
    input wire logic [DIG_ADDR_W-1:0] loop_count_imm_i,
    input wire logic [DIG_ADDR_W-1:0] loop_count_reg_i,
    input wire logic [DIG_ADDR_W-1:0] loop_end_expr_i,
    input wire logic [DIG_ADDR_W-1:0] next_pc_i,
    input wire logic [DIG_ADDR_W-1:0] fetch_addr_i,
    input dig_am_t addr_mode_i,
    input wire logic [DIG_ADDR_W-1:0] address_modifier_i,
    output logic [DIG_ACC_W-1:0] acc_o,
    output logic acc_we_o,
    output logic [DIG_WORD_W-1:0] bit_word_o,
    output logic bit_we_o,
    output logic [7:0] condition_flags_o,
    output logic [DIG_ADDR_W-1:0] status_word_o,
    output logic [DIG_ADDR_W-1:0] loop_end_address_o,
    output logic [DIG_ADDR_W-1:0] loop_counter_o,
    output logic [DIG_PTR_W-1:0] stack_pointer_o,
    output logic loop_active_flag_o,
    output logic [DIG_ADDR_W-1:0] pc_redirect_o,
    output logic pc_redirect_we_o,
    output logic illegal_move_o,
    output logic bus_busy_o,
    output logic [DIG_ADDR_W-1:0] modifier_used_o,
    output logic busy_o
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [DIG_ACC_W-1:0] acc;
        logic acc_we;
        logic [DIG_WORD_W-1:0] bword;
        logic bit_we;
        logic [7:0] flags;
        logic [DIG_ADDR_W-1:0] stat;
        logic [DIG_ADDR_W-1:0] lend;
        logic [DIG_ADDR_W-1:0] lcnt;
        logic [DIG_PTR_W-1:0] sptr;
        logic [DIG_ADDR_W-1:0] pc;
        logic pc_we;
        logic illegal;
        logic busbusy;
        logic [DIG_ADDR_W-1:0] modused;
        dig_lstate_t ls;
        logic [DIG_ADDR_W-1:0] cnt_hold;
        logic [DIG_ADDR_W-1:0] end_hold;
        logic [DIG_ADDR_W-1:0] pc_hold;
    } dig_state_t;

    dig_state_t s_r;
    dig_state_t s_nxt;
    dig_stack_if stk ();
    logic [DIG_WORD_W-1:0] mid;
    logic [DIG_WORD_W-1:0] res;
    logic tested;
    logic no_move_op;
    logic loop_end_hit;

    dig_stack u_stack (
        .core_clk_i(core_clk_i),
        .st(stk.mem)
    );

    assign mid = acc_i[DIG_MID_HI:DIG_MID_LO];
    assign tested = bit_word_i[bit_sel_i];
    assign loop_end_hit = s_r.stat[DIG_LOOP_FLAG_BIT] && (fetch_addr_i == s_r.lend);
    // Operations that cannot share their cycle with a parallel move
    assign no_move_op = (op_i == DIG_OP_DIV) || (op_i == DIG_OP_MSHIFT) ||
                        (op_i == DIG_OP_INC) || (op_i == DIG_OP_SUBONE) || // [RQ3]
                        (op_i == DIG_OP_MASK_CLEAR) || (op_i == DIG_OP_MASK_SET); // [RQ7]

    // ==========================================================
    // Next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.acc_we = 1'b0;
        s_nxt.bit_we = 1'b0;
        s_nxt.pc_we = 1'b0;
        s_nxt.illegal = 1'b0;
        s_nxt.busbusy = 1'b0;
        res = mid;
        stk.push = 1'b0;
        stk.pull = 1'b0;
        stk.sptr = s_r.sptr;
        stk.wr_high = s_r.lend;
        stk.wr_low = s_r.lcnt;
        // Modifier only for updating indirect modes
        case (addr_mode_i)
            DIG_AM_POST_INC, DIG_AM_POST_DOWN, DIG_AM_POST_INC_OFS,
            DIG_AM_POST_DOWN_OFS, DIG_AM_INDEXED, DIG_AM_PRE_DOWN: begin
                s_nxt.modused = address_modifier_i; // [RQ17]
            end
            default: begin
                s_nxt.modused = '0; // [RQ17]
            end
        endcase
        case (s_r.ls)
            DIG_LS_PUSH2: begin
                // Second push: body start and status word
                stk.push = 1'b1; // [RQ18]
                stk.sptr = s_r.sptr + DIG_PTR_W'(1);
                stk.wr_high = s_r.pc_hold; // [RQ15]
                stk.wr_low = s_r.stat;
                s_nxt.sptr = s_r.sptr + DIG_PTR_W'(1);
                s_nxt.lend = s_r.end_hold - DIG_ONE16; // [RQ18]
                s_nxt.stat[DIG_LOOP_FLAG_BIT] = 1'b1; // [RQ19]
                s_nxt.ls = DIG_LS_IDLE;
            end
            default: begin
                s_nxt.ls = DIG_LS_IDLE;
                if (loop_end_hit) begin
                    // Loop end runs alongside fetch, no extra cycle
                    if (s_r.lcnt != DIG_ONE16) begin
                        s_nxt.lcnt = s_r.lcnt - DIG_ONE16; // [RQ20]
                        s_nxt.pc = stk.top_high; // [RQ11]
                        s_nxt.pc_we = 1'b1;
                    end else begin
                        // Restore status, drop top, pull saved loop registers
                        s_nxt.stat = stk.top_low; // [RQ20]
                        s_nxt.lend = stk.below_high; // [RQ16]
                        s_nxt.lcnt = stk.below_low; // [RQ16]
                        s_nxt.sptr = s_r.sptr - DIG_PTR_W'(2);
                        stk.pull = 1'b1;
                    end
                end else if (op_valid_i) begin
                    if (par_move_i && no_move_op) begin
                        s_nxt.illegal = 1'b1; // [RQ3] [RQ7]
                    end
                    // ALU never drives the buses itself
                    s_nxt.busbusy = 1'b0; // [RQ2]
                    case (op_i)
                        DIG_OP_ADD, DIG_OP_SUB, DIG_OP_NEG, DIG_OP_CLR,
                        DIG_OP_INC, DIG_OP_SUBONE, DIG_OP_DIV, DIG_OP_MSHIFT: begin
                            s_nxt.acc = acc_i;
                            case (op_i)
                                DIG_OP_ADD: s_nxt.acc = acc_i + {{32{src_i[23]}}, src_i};
                                DIG_OP_SUB: s_nxt.acc = acc_i - {{32{src_i[23]}}, src_i};
                                DIG_OP_NEG: s_nxt.acc = -acc_i;
                                DIG_OP_CLR: s_nxt.acc = '0;
                                DIG_OP_INC: s_nxt.acc = acc_i + DIG_ACC_W'(1);
                                DIG_OP_SUBONE: s_nxt.acc = acc_i - DIG_ACC_W'(1);
                                DIG_OP_DIV: s_nxt.acc = {acc_i[DIG_ACC_W-2:0], 1'b0};
                                default: s_nxt.acc = {acc_i[DIG_ACC_W-1], acc_i[DIG_ACC_W-1:1]};
                            endcase
                            s_nxt.acc_we = 1'b1; // [RQ1] [RQ2]
                            s_nxt.flags[2] = (s_nxt.acc == '0); // [RQ1]
                            s_nxt.flags[3] = s_nxt.acc[DIG_ACC_W-1];
                        end
                        DIG_OP_AND, DIG_OP_OR, DIG_OP_EOR, DIG_OP_NOT: begin
                            case (op_i)
                                DIG_OP_AND: res = mid & src_i;
                                DIG_OP_OR: res = mid | src_i;
                                DIG_OP_EOR: res = mid ^ src_i;
                                default: res = ~mid;
                            endcase
                            // Only the middle portion changes; move may hit others
                            s_nxt.acc = {acc_i[DIG_ACC_W-1:DIG_MID_HI+1], res,
                                         acc_i[DIG_MID_LO-1:0]}; // [RQ5] [RQ6]
                            s_nxt.acc_we = 1'b1; // [RQ4]
                            s_nxt.flags[2] = (res == '0); // [RQ4]
                            s_nxt.flags[3] = res[DIG_WORD_W-1];
                        end
                        DIG_OP_MASK_CLEAR: begin
                            s_nxt.flags = s_r.flags & imm_mask_i; // [RQ4]
                        end
                        DIG_OP_MASK_SET: begin
                            s_nxt.flags = s_r.flags | imm_mask_i; // [RQ4]
                        end
                        DIG_OP_BIT_CLEAR, DIG_OP_BIT_SET, DIG_OP_BIT_TOGGLE,
                        DIG_OP_BIT_ONLY: begin
                            s_nxt.flags[DIG_CARRY_BIT] = tested; // [RQ9]
                            s_nxt.bword = bit_word_i;
                            case (op_i)
                                DIG_OP_BIT_CLEAR: s_nxt.bword[bit_sel_i] = 1'b0; // [RQ10]
                                DIG_OP_BIT_SET: s_nxt.bword[bit_sel_i] = 1'b1; // [RQ10]
                                DIG_OP_BIT_TOGGLE: s_nxt.bword[bit_sel_i] = ~tested; // [RQ8]
                                default: s_nxt.bword = bit_word_i; // [RQ8]
                            endcase
                            s_nxt.bit_we = (op_i != DIG_OP_BIT_ONLY); // [RQ8]
                        end
                        DIG_OP_LOOP_IMM, DIG_OP_LOOP_REG: begin
                            // First push: old loop address and counter
                            stk.push = 1'b1; // [RQ13]
                            stk.sptr = s_r.sptr + DIG_PTR_W'(1);
                            s_nxt.sptr = s_r.sptr + DIG_PTR_W'(1); // [RQ13]
                            s_nxt.lcnt = (op_i == DIG_OP_LOOP_IMM) ?
                                       loop_count_imm_i : loop_count_reg_i; // [RQ12] [RQ14]
                            s_nxt.end_hold = loop_end_expr_i;
                            s_nxt.pc_hold = next_pc_i; // [RQ15]
                            s_nxt.ls = DIG_LS_PUSH2;
                        end
                        DIG_OP_LOOP_EXIT: begin
                            // Early exit uses the same unwind as normal end
                            s_nxt.stat = stk.top_low; // [RQ16]
                            s_nxt.lend = stk.below_high;
                            s_nxt.lcnt = stk.below_low;
                            s_nxt.sptr = s_r.sptr - DIG_PTR_W'(2);
                            stk.pull = 1'b1;
                        end
                        default: begin
                            s_nxt.acc_we = 1'b0;
                        end
                    endcase
                end
            end
        endcase
        s_nxt.pc = s_nxt.pc_we ? s_nxt.pc : s_r.pc;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.stat <= DIG_STAT_RST;
            s_r.lend <= DIG_LEND_RST;
            s_r.lcnt <= DIG_LCNT_RST;
            s_r.sptr <= DIG_PTR_RST;
            s_r.ls <= DIG_LS_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign acc_o = s_r.acc;
    assign acc_we_o = s_r.acc_we;
    assign bit_word_o = s_r.bword;
    assign bit_we_o = s_r.bit_we;
    assign condition_flags_o = s_r.flags;
    assign status_word_o = s_r.stat;
    assign loop_end_address_o = s_r.lend;
    assign loop_counter_o = s_r.lcnt;
    assign stack_pointer_o = s_r.sptr;
    assign loop_active_flag_o = s_r.stat[DIG_LOOP_FLAG_BIT];
    assign pc_redirect_o = s_r.pc;
    assign pc_redirect_we_o = s_r.pc_we;
    assign illegal_move_o = s_r.illegal;
    assign bus_busy_o = s_r.busbusy;
    assign modifier_used_o = s_r.modused;
    assign busy_o = (s_r.ls == DIG_LS_PUSH2);
endmodule

// [src/dig_pkg.sv]
// Package for the instruction group execution block.
// Assumes a 24-bit data path, 56-bit accumulators and 16-bit loop registers.
package dig_pkg;
    // ==========================================================
    // Widths and field positions
    localparam int DIG_WORD_W = 24;
    localparam int DIG_ACC_W = 56;
    localparam int DIG_ADDR_W = 16;
    localparam int DIG_PTR_W = 4;
    localparam int DIG_MID_LO = 24;
    localparam int DIG_MID_HI = 47;
    localparam int DIG_CARRY_BIT = 0;
    localparam int DIG_LOOP_FLAG_BIT = 15;
    localparam int DIG_STACK_DEPTH = 16;
    // ==========================================================
    // Reset values and constants
    localparam logic [15:0] DIG_LCNT_RST = 16'h0000;
    localparam logic [15:0] DIG_LEND_RST = 16'h0000;
    localparam logic [15:0] DIG_STAT_RST = 16'h0000;
    localparam logic [3:0] DIG_PTR_RST = 4'h0;
    localparam logic [15:0] DIG_ONE16 = 16'h0001;
    // ==========================================================
    // Instruction operations
    typedef enum logic [4:0] {
        DIG_OP_NOP, DIG_OP_ADD, DIG_OP_SUB, DIG_OP_NEG, DIG_OP_CLR,
        DIG_OP_INC, DIG_OP_SUBONE, DIG_OP_DIV, DIG_OP_MSHIFT,
        DIG_OP_AND, DIG_OP_OR, DIG_OP_EOR, DIG_OP_NOT,
        DIG_OP_MASK_CLEAR, DIG_OP_MASK_SET,
        DIG_OP_BIT_CLEAR, DIG_OP_BIT_SET, DIG_OP_BIT_TOGGLE, DIG_OP_BIT_ONLY,
        DIG_OP_LOOP_IMM, DIG_OP_LOOP_REG, DIG_OP_LOOP_EXIT
    } dig_op_t;
    // Addressing modes
    typedef enum logic [3:0] {
        DIG_AM_DIRECT, DIG_AM_NO_UPDATE, DIG_AM_POST_INC, DIG_AM_POST_DOWN,
        DIG_AM_POST_INC_OFS, DIG_AM_POST_DOWN_OFS, DIG_AM_INDEXED,
        DIG_AM_PRE_DOWN, DIG_AM_SPECIAL
    } dig_am_t;
    typedef enum logic [1:0] {DIG_LS_IDLE, DIG_LS_PUSH2} dig_lstate_t;
endpackage

// [src/dig_stack.sv]
// System stack memory, high and low halves per location.
// Assumes the controller never pushes and pulls in one cycle.
`timescale 1ns/10ps
module dig_stack
    import dig_pkg::*;
(
    input wire logic core_clk_i,
    dig_stack_if.mem st
);
    logic [2*DIG_ADDR_W-1:0] mem_r [DIG_STACK_DEPTH];
    logic [DIG_PTR_W-1:0] below;
    // ==========================================================
    // Write at the incremented pointer
    always_ff @(posedge core_clk_i) begin
        if (st.push) begin
            mem_r[st.sptr] <= {st.wr_high, st.wr_low};
        end
    end
    always_comb begin
        below = st.sptr - DIG_PTR_W'(1);
        {st.top_high, st.top_low} = mem_r[st.sptr];
        {st.below_high, st.below_low} = mem_r[below];
    end
endmodule

// [src/dig_stack_if.sv]
// Interface between the loop sequencer and the system stack.
// Assumes one clock; writes take effect on that clock, reads are combinational.
`timescale 1ns/10ps
interface dig_stack_if;
    import dig_pkg::*;
    logic push;
    logic pull;
    logic [DIG_PTR_W-1:0] sptr;
    logic [DIG_ADDR_W-1:0] wr_high;
    logic [DIG_ADDR_W-1:0] wr_low;
    logic [DIG_ADDR_W-1:0] top_high;
    logic [DIG_ADDR_W-1:0] top_low;
    logic [DIG_ADDR_W-1:0] below_high;
    logic [DIG_ADDR_W-1:0] below_low;
    modport ctl (output push, output pull, output sptr, output wr_high, output wr_low,
                 input top_high, input top_low, input below_high, input below_low);
    modport mem (input push, input pull, input sptr, input wr_high, input wr_low,
                 output top_high, output top_low, output below_high, output below_low);
endinterface

// [verification/dig_exec_bench.sv]
// Bench for the instruction group execution block with a memory model.
// Assumes results show at the edge that takes an op; memory write-back one cycle later.
`timescale 1ns/10ps
module dig_exec_bench;
    import dig_pkg::*;
    typedef struct {dig_op_t op; logic par; logic ill; logic [DIG_ACC_W-1:0] acc;} dig_row_t;
    // ==========================================================
    // Stimulus and observed signals
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic op_valid_i = 1'b0;
    dig_op_t op_i = DIG_OP_NOP;
    logic par_move_i = 1'b0;
    logic [DIG_ACC_W-1:0] acc_i = 56'hAB123456654321;
    logic [DIG_WORD_W-1:0] src_i = 24'h0F0F0F;
    logic [DIG_WORD_W-1:0] mem_rd;
    logic [DIG_WORD_W-1:0] mem_val = 24'h000000;
    logic [DIG_WORD_W-1:0] exp_word;
    logic mem_load = 1'b0;
    logic [4:0] bit_sel_i = 5'h00;
    logic [DIG_ADDR_W-1:0] cnt_imm = 16'h0002;
    logic [DIG_ADDR_W-1:0] cnt_reg = 16'h0003;
    logic [DIG_ADDR_W-1:0] end_expr = 16'h0040;
    logic [DIG_ADDR_W-1:0] next_pc = 16'h0031;
    logic [DIG_ADDR_W-1:0] fetch = 16'h0000;
    logic [DIG_ADDR_W-1:0] modifier = 16'h00FF;
    dig_am_t addr_mode_i = DIG_AM_DIRECT;
    logic [DIG_ACC_W-1:0] acc_o;
    logic [DIG_WORD_W-1:0] bit_word_o;
    logic [7:0] flags;
    logic [DIG_ADDR_W-1:0] swd, lend, lcnt, pc, mod_used;
    logic [DIG_PTR_W-1:0] sptr;
    logic acc_we, bit_we, lact, pc_we, illm, bus_busy, busy;
    int n_fail = 0;
    int n_checks = 0;
    int cycles = 0;
    dig_op_t bops [4] = '{DIG_OP_BIT_CLEAR, DIG_OP_BIT_SET, DIG_OP_BIT_TOGGLE, DIG_OP_BIT_ONLY};
    dig_row_t rows [12] = '{
        '{DIG_OP_AND, 1'b1, 1'b0, 56'hAB020406654321}, '{DIG_OP_OR, 1'b0, 1'b0, 56'hAB1F3F5F654321},
        '{DIG_OP_EOR, 1'b1, 1'b0, 56'hAB1D3B59654321}, '{DIG_OP_NOT, 1'b0, 1'b0, 56'hABEDCBA9654321},
        '{DIG_OP_ADD, 1'b1, 1'b0, 56'h0}, '{DIG_OP_SUB, 1'b0, 1'b0, 56'h0},
        '{DIG_OP_DIV, 1'b1, 1'b1, 56'h0}, '{DIG_OP_MSHIFT, 1'b1, 1'b1, 56'h0},
        '{DIG_OP_INC, 1'b1, 1'b1, 56'h0}, '{DIG_OP_SUBONE, 1'b1, 1'b1, 56'h0},
        '{DIG_OP_MASK_CLEAR, 1'b1, 1'b1, 56'h0}, '{DIG_OP_MASK_SET, 1'b1, 1'b1, 56'h0}};
    // ==========================================================
    // Design, memory model, clock and hang guard
    dig_exec dig_exec_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i),
        .op_i(op_i), .par_move_i(par_move_i), .acc_i(acc_i), .src_i(src_i), .bit_word_i(mem_rd),
        .bit_sel_i(bit_sel_i), .imm_mask_i(8'h0F), .loop_count_imm_i(cnt_imm),
        .loop_count_reg_i(cnt_reg), .loop_end_expr_i(end_expr), .next_pc_i(next_pc),
        .fetch_addr_i(fetch), .addr_mode_i(addr_mode_i), .address_modifier_i(modifier),
        .acc_o(acc_o), .acc_we_o(acc_we), .bit_word_o(bit_word_o), .bit_we_o(bit_we),
        .condition_flags_o(flags), .status_word_o(swd), .loop_end_address_o(lend),
        .loop_counter_o(lcnt), .stack_pointer_o(sptr), .loop_active_flag_o(lact),
        .pc_redirect_o(pc), .pc_redirect_we_o(pc_we), .illegal_move_o(illm),
        .bus_busy_o(bus_busy), .modifier_used_o(mod_used), .busy_o(busy));
    dig_mem_model dig_mem_model_inst (.core_clk_i(core_clk_i), .load_i(mem_load),
        .load_val_i(mem_val), .wr_i(bit_we), .wr_val_i(bit_word_o), .rd_o(mem_rd));
    always #50 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            report_and_stop();
        end
    end
    // ==========================================================
    // Tasks
    task automatic chk(input string what, input logic [DIG_ACC_W-1:0] exp,
                       input logic [DIG_ACC_W-1:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run(input dig_op_t op, input logic par);
        @(negedge core_clk_i);
        op_i = op;
        par_move_i = par;
        op_valid_i = 1'b1;
        @(negedge core_clk_i);
        op_valid_i = 1'b0;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        chk("reset state", 56'h0, {sptr, lcnt, lend, swd, busy, lact, pc_we});
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].par);
            chk("illegal move", rows[i].ill, illm);
            if (rows[i].op inside {DIG_OP_AND, DIG_OP_OR, DIG_OP_EOR, DIG_OP_NOT}) begin
                chk("logic result", rows[i].acc, acc_o);
            end else if (!(rows[i].op inside {DIG_OP_MASK_CLEAR, DIG_OP_MASK_SET})) begin
                chk("acc write", 1'b1, acc_we);
            end
        end
        // Bit 1 of the pattern is set, bit 23 clear: both polarities tested
        for (int k = 0; k < 8; k++) begin
            @(negedge core_clk_i);
            mem_load = 1'b1;
            mem_val = 24'h5A5A5A;
            bit_sel_i = (k < 4) ? 5'h01 : 5'h17;
            @(negedge core_clk_i);
            mem_load = 1'b0;
            exp_word = mem_val;
            case (k % 4)
                0: exp_word[bit_sel_i] = 1'b0;
                1: exp_word[bit_sel_i] = 1'b1;
                2: exp_word[bit_sel_i] = ~exp_word[bit_sel_i];
                default: ;
            endcase
            run(bops[k % 4], 1'b0);
            chk("carry", mem_val[bit_sel_i], flags[DIG_CARRY_BIT]);
            @(negedge core_clk_i);
            chk("bit word", exp_word, mem_rd);
        end
        for (int m = 0; m < 9; m++) begin
            @(negedge core_clk_i);
            addr_mode_i = dig_am_t'(m);
            @(negedge core_clk_i);
            chk("modifier", (m > 1 && m < 8) ? modifier : 16'h0000, mod_used);
        end
        run(DIG_OP_LOOP_IMM, 1'b0);
        chk("first push", {4'h1, cnt_imm, 1'b1}, {sptr, lcnt, busy});
        @(negedge core_clk_i);
        chk("second push", {4'h2, end_expr - 16'h0001, 2'h3}, {sptr, lend, swd[15], lact});
        fetch = end_expr - 16'h0001;
        @(negedge core_clk_i);
        chk("loop repeat", {1'b1, next_pc, 16'h0001}, {pc_we, pc, lcnt});
        @(negedge core_clk_i);
        chk("loop end", {1'b0, 4'h0, 16'h0000, 16'h0000, 1'b0}, {pc_we, sptr, lcnt, lend, lact});
        fetch = 16'h0000;
        run(DIG_OP_LOOP_REG, 1'b0);
        chk("register count", cnt_reg, lcnt);
        run(DIG_OP_LOOP_EXIT, 1'b0);
        chk("early exit", {4'h0, 16'h0000, 1'b0}, {sptr, lcnt, lact});
        report_and_stop();
    end
endmodule
bind dig_exec dig_exec_props dig_exec_props_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .op_valid_i(op_valid_i), .op_i(op_i), .par_move_i(par_move_i), .acc_i(acc_i),
    .bit_word_i(bit_word_i), .bit_sel_i(bit_sel_i), .loop_end_expr_i(loop_end_expr_i),
    .fetch_addr_i(fetch_addr_i), .addr_mode_i(addr_mode_i),
    .address_modifier_i(address_modifier_i), .acc_o(acc_o), .acc_we_o(acc_we_o),
    .condition_flags_o(condition_flags_o), .status_word_o(status_word_o),
    .loop_end_address_o(loop_end_address_o), .loop_counter_o(loop_counter_o),
    .stack_pointer_o(stack_pointer_o), .loop_active_flag_o(loop_active_flag_o),
    .pc_redirect_we_o(pc_redirect_we_o), .illegal_move_o(illegal_move_o),
    .bus_busy_o(bus_busy_o), .modifier_used_o(modifier_used_o), .busy_o(busy_o));

// [verification/dig_exec_props.sv]
// Checker for the instruction group execution block.
// Assumes it is bound to dig_exec and sees only that module's ports.
`timescale 1ns/10ps
module dig_exec_props
    import dig_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic op_valid_i,
    input dig_op_t op_i,
    input wire logic par_move_i,
    input wire logic [DIG_ACC_W-1:0] acc_i,
    input wire logic [DIG_WORD_W-1:0] bit_word_i,
    input wire logic [4:0] bit_sel_i,
    input wire logic [DIG_ADDR_W-1:0] loop_end_expr_i,
    input wire logic [DIG_ADDR_W-1:0] fetch_addr_i,
    input dig_am_t addr_mode_i,
    input wire logic [DIG_ADDR_W-1:0] address_modifier_i,
    input wire logic [DIG_ACC_W-1:0] acc_o,
    input wire logic acc_we_o,
    input wire logic [7:0] condition_flags_o,
    input wire logic [DIG_ADDR_W-1:0] status_word_o,
    input wire logic [DIG_ADDR_W-1:0] loop_end_address_o,
    input wire logic [DIG_ADDR_W-1:0] loop_counter_o,
    input wire logic [DIG_PTR_W-1:0] stack_pointer_o,
    input wire logic loop_active_flag_o,
    input wire logic pc_redirect_we_o,
    input wire logic illegal_move_o,
    input wire logic bus_busy_o,
    input wire logic [DIG_ADDR_W-1:0] modifier_used_o,
    input wire logic busy_o
);
    // ==========================================================
    // Helpers: an op is only taken when not busy and not at a loop end
    logic hit;
    logic take;
    assign hit = !busy_o && loop_active_flag_o && (fetch_addr_i == loop_end_address_o);
    assign take = op_valid_i && !busy_o && !hit;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    // ==========================================================
    // Loop start steps
    sequence loop_start_s;
        take && (op_i inside {DIG_OP_LOOP_IMM, DIG_OP_LOOP_REG});
    endsequence
    sequence first_push_s;
        busy_o && (stack_pointer_o == $past(stack_pointer_o) + 4'h1);
    endsequence
    sequence second_push_s;
        (stack_pointer_o == $past(stack_pointer_o, 2) + 4'h2) && loop_active_flag_o
        && status_word_o[DIG_LOOP_FLAG_BIT]
        && (loop_end_address_o == $past(loop_end_expr_i, 2) - 16'h0001);
    endsequence
    // ==========================================================
    // Properties
    a_loop_start_push: assert property (loop_start_s |=> first_push_s ##1 second_push_s)
        else $error("loop start push sequence wrong");
    a_bus_stays_free: assert property (bus_busy_o == 1'b0)
        else $error("data bus claimed by alu op");
    a_move_refused: assert property (take && par_move_i && (op_i inside {DIG_OP_DIV,
        DIG_OP_MSHIFT, DIG_OP_INC, DIG_OP_SUBONE, DIG_OP_MASK_CLEAR, DIG_OP_MASK_SET})
        |=> illegal_move_o) else $error("parallel move not refused");
    a_move_allowed: assert property (take && par_move_i && (op_i inside {DIG_OP_ADD,
        DIG_OP_SUB, DIG_OP_AND, DIG_OP_OR, DIG_OP_EOR, DIG_OP_NOT}) |=> !illegal_move_o)
        else $error("legal parallel move refused");
    a_arith_one_cycle: assert property (take && (op_i inside {DIG_OP_ADD, DIG_OP_SUB,
        DIG_OP_NEG, DIG_OP_CLR}) |=> acc_we_o) else $error("arithmetic result late");
    a_logic_middle: assert property (take && (op_i inside {DIG_OP_AND, DIG_OP_OR,
        DIG_OP_EOR, DIG_OP_NOT}) |=> acc_we_o && (acc_o[55:48] == $past(acc_i[55:48]))
        && (acc_o[23:0] == $past(acc_i[23:0]))) else $error("logic op touched outer bits");
    a_carry_pretest: assert property (take && (op_i inside {DIG_OP_BIT_CLEAR,
        DIG_OP_BIT_SET, DIG_OP_BIT_TOGGLE, DIG_OP_BIT_ONLY}) |=>
        condition_flags_o[DIG_CARRY_BIT] == $past(bit_word_i[bit_sel_i]))
        else $error("carry not the tested bit");
    a_loop_repeat: assert property (hit && (loop_counter_o != 16'h0001) |=> pc_redirect_we_o
        && (loop_counter_o == $past(loop_counter_o) - 16'h0001)) else $error("loop repeat wrong");
    a_loop_finish: assert property (hit && (loop_counter_o == 16'h0001) |=> !pc_redirect_we_o
        && (stack_pointer_o == $past(stack_pointer_o) - 4'h2)) else $error("loop end wrong");
    a_modifier_use: assert property (!$past(rst_i) |-> modifier_used_o ==
        (($past(addr_mode_i) inside {DIG_AM_POST_INC, DIG_AM_POST_DOWN, DIG_AM_POST_INC_OFS,
        DIG_AM_POST_DOWN_OFS, DIG_AM_INDEXED, DIG_AM_PRE_DOWN}) ? $past(address_modifier_i)
        : 16'h0000)) else $error("address modifier use wrong");
endmodule

// [verification/dig_mem_model.sv]
// Data memory model holding the word under bit test.
// Assumes the bench preloads the word and the block writes back on its strobe.
`timescale 1ns/10ps
module dig_mem_model
    import dig_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic load_i,
    input wire logic [DIG_WORD_W-1:0] load_val_i,
    input wire logic wr_i,
    input wire logic [DIG_WORD_W-1:0] wr_val_i,
    output logic [DIG_WORD_W-1:0] rd_o
);
    // ==========================================================
    // Storage: write lands on the edge after the strobe, so the test reads the new word one cycle later
    always_ff @(posedge core_clk_i) begin
        if (load_i) begin
            rd_o <= load_val_i;
        end else if (wr_i) begin
            rd_o <= wr_val_i;
        end
    end
endmodule
